// *** src/ldcr_cfg.svh ***
// Offsets, field positions, reset values and lookup figures of the dimming config bank.
// Assumes inclusion by bare name from the package and the bank module only.
`ifndef LDCR_CFG_SVH
`define LDCR_CFG_SVH

`define LDCR_ADDR_W       8
`define LDCR_DATA_W       8
`define LDCR_OFS_CORE     8'h63
`define LDCR_OFS_HYBRID   8'h65
`define LDCR_OFS_MODE     8'h66
`define LDCR_OFS_TRIM     8'h67

`define LDCR_RST_CORE     8'h00
`define LDCR_RST_HYBRID   8'h00
`define LDCR_RST_MODE     8'h00
`define LDCR_RST_TRIM     8'h77
`define LDCR_RST_MAX_MA   8'h19

// Core register: hybrid enable and register current scale
`define LDCR_HYB_EN_BIT   0
`define LDCR_SCALE_MSB    6
`define LDCR_SCALE_LSB    4
// Hybrid, PWM clock and dither register
`define LDCR_SLOPE_MSB    7
`define LDCR_SLOPE_LSB    5
`define LDCR_PCLK_MSB     4
`define LDCR_PCLK_LSB     3
`define LDCR_DITH_MSB     2
`define LDCR_DITH_LSB     0
// Dimming mode register
`define LDCR_RSVD_BIT     7
`define LDCR_SWPT_MSB     6
`define LDCR_SWPT_LSB     4
`define LDCR_EXTRES_BIT   3
`define LDCR_SPLIT_BIT    2
`define LDCR_BRT_MSB      1
`define LDCR_BRT_LSB      0
// Trim register
`define LDCR_TRIM2_MSB    7
`define LDCR_TRIM2_LSB    4
`define LDCR_TRIM1_MSB    3
`define LDCR_TRIM1_LSB    0

// Slope gain in 1/1024 units: unity plus equal steps
`define LDCR_GAIN_UNITY   11'h400
`define LDCR_GAIN_STEP    11'h018
// Base PWM generation clock in MHz, doubled per code step
`define LDCR_PCLK_BASE    6'h05
// Top nibble of a 16-bit current setting zero means below 1/16 scale
`define LDCR_SMALL_MSB    15
`define LDCR_SMALL_LSB    12

`endif

// *** src/ldcr_pkg.sv ***
// Types shared by the dimming config bank and its users.
// Assumes ldcr_cfg.svh is on the include path.
`include "ldcr_cfg.svh"

package ldcr_pkg;

	typedef enum logic [1:0] {
		LDCR_BRT_PIN_DUTY,
		LDCR_BRT_DUTY_X_REG,
		LDCR_BRT_REG_ONLY,
		LDCR_BRT_DIRECT
	} ldcr_brt_src_type;

	typedef struct packed {
		logic [`LDCR_ADDR_W-1:0] addr;
		logic [`LDCR_DATA_W-1:0] wdata;
		logic                    wr;
		logic                    rd;
	} ldcr_bus_req_type;

	typedef struct packed {
		logic             hybrid_on;
		logic [10:0]      slope_gain;
		logic [9:0]       switch_pm;
		logic [5:0]       pwm_clk_mhz;
		logic [2:0]       dither_bits;
		logic             use_resistor;
		logic [7:0]       max_ma;
		logic             small_fet;
		ldcr_brt_src_type brt_src;
		logic [15:0]      brightness;
		logic             direct_pwm_en;
		logic             direct_pwm;
		logic signed [7:0] trim1;
		logic signed [7:0] trim2;
	} ldcr_dim_out_type;

endpackage : ldcr_pkg

// *** src/ldcr_bank.sv ***
// Dimming configuration register bank of a four-sink LED driver, with decode of every field.
// Assumes a single-clock register master and brightness inputs synchronous to clk_sys_i.
// Limitation: trims of sinks 3 and 4 and all fault settings are held outside this block.
//
// Function
// - Hybrid slope gain 1.000 to 1.164, equal steps
// - PWM clock 5/10/20/40 MHz from 2-bit code
// - Dither off, 1-3 bits, top bit gives 4
// - Hybrid switch point from eight-entry percentage table
// - External bit picks resistor or register current scaling
// - Split bit enables small FET below 1/16
// - Mode 00 brightness equals PWM input duty
// - Mode 01 brightness is duty times register
// - Mode 10 register only; 11 direct pin
// - Sink 2 trim +6.5% to -7.4%
// - Sink 1 trim uses same encoding
// - Slope and switch point only in hybrid
// - Scale field gives 25 to 150 mA
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "ldcr_cfg.svh"

module ldcr_bank (
	input  wire logic                   clk_sys_i,     // System clock, 50 MHz
	input  wire logic                   rst_b_i,       // Async reset, active low
	input  wire ldcr_pkg::ldcr_bus_req_type bus_i,     // Register request
	output logic [`LDCR_DATA_W-1:0]     rdata_o,       // Read data, cycle after read
	input  wire logic [15:0]            pwm_duty_i,    // Measured PWM input duty
	input  wire logic                   pwm_pin_i,     // PWM input pin level
	input  wire logic [15:0]            brt_reg_i,     // Brightness register value
	input  wire logic [15:0]            cur_set_i,     // Current setting, full scale 16 bit
	output ldcr_pkg::ldcr_dim_out_type  dim_o          // Decoded dimming controls
);
	import ldcr_pkg::*;

	typedef struct packed {
		logic [7:0]       core_reg;
		logic [7:0]       hyb_reg;
		logic [7:0]       mode_reg;
		logic [7:0]       trim_reg;
		logic [7:0]       rdata;
		ldcr_dim_out_type dim;
	} ldcr_state_type;

	ldcr_state_type cur;
	ldcr_state_type next_cur;

	// Trim in 0.1 % units, positive raises current
	function automatic logic signed [7:0] ldcr_trim(input logic [3:0] code);
		logic signed [7:0] t;
		t = 8'sh00;
		case (code)
			4'h0: begin
				t = 8'sh41;
			end
			4'h1: begin
				t = 8'sh38;
			end
			4'h2: begin
				t = 8'sh2F;
			end
			4'h3: begin
				t = 8'sh25;
			end
			4'h4: begin
				t = 8'sh1C;
			end
			4'h5: begin
				t = 8'sh13;
			end
			4'h6: begin
				t = 8'sh09;
			end
			4'h7: begin
				t = 8'sh00;
			end
			4'h8: begin
				t = 8'shF7;
			end
			4'h9: begin
				t = 8'shED;
			end
			4'hA: begin
				t = 8'shE4;
			end
			4'hB: begin
				t = 8'shDB;
			end
			4'hC: begin
				t = 8'shD1;
			end
			4'hD: begin
				t = 8'shC8;
			end
			4'hE: begin
				t = 8'shBF;
			end
			default: begin
				t = 8'shB6;
			end
		endcase
		return t;
	endfunction : ldcr_trim

	// Switch point in 0.1 % of full brightness
	function automatic logic [9:0] ldcr_swpt(input logic [2:0] code);
		logic [9:0] p;
		p = 10'h000;
		case (code)
			3'h0: begin
				p = 10'h1F4;
			end
			3'h1: begin
				p = 10'h196;
			end
			3'h2: begin
				p = 10'h139;
			end
			3'h3: begin
				p = 10'h0FA;
			end
			3'h4: begin
				p = 10'h0DB;
			end
			3'h5: begin
				p = 10'h0BC;
			end
			3'h6: begin
				p = 10'h09C;
			end
			default: begin
				p = 10'h07D;
			end
		endcase
		return p;
	endfunction : ldcr_swpt

	// Maximum sink current in mA from the register scale
	function automatic logic [7:0] ldcr_scale(input logic [2:0] code);
		logic [7:0] m;
		m = 8'h00;
		case (code)
			3'h0: begin
				m = 8'h19;
			end
			3'h1: begin
				m = 8'h1E;
			end
			3'h2: begin
				m = 8'h32;
			end
			3'h3: begin
				m = 8'h3C;
			end
			3'h4: begin
				m = 8'h50;
			end
			3'h5: begin
				m = 8'h64;
			end
			3'h6: begin
				m = 8'h78;
			end
			default: begin
				m = 8'h96;
			end
		endcase
		return m;
	endfunction : ldcr_scale

	always_comb begin
		logic [31:0]      prod;
		logic [2:0]       slope_code;
		logic [1:0]       pclk_code;
		logic [2:0]       dith_code;
		ldcr_brt_src_type src;
		prod       = 32'h0000_0000;
		slope_code = 3'h0;
		pclk_code  = 2'h0;
		dith_code  = 3'h0;
		src        = LDCR_BRT_PIN_DUTY;
		next_cur   = cur;

		// Register writes
		if (bus_i.wr) begin
			case (bus_i.addr)
				`LDCR_OFS_CORE: begin
					next_cur.core_reg = bus_i.wdata;
				end
				`LDCR_OFS_HYBRID: begin
					next_cur.hyb_reg = bus_i.wdata;
				end
				`LDCR_OFS_MODE: begin
					next_cur.mode_reg = bus_i.wdata;
					next_cur.mode_reg[`LDCR_RSVD_BIT] = 1'b0;
				end
				`LDCR_OFS_TRIM: begin
					next_cur.trim_reg = bus_i.wdata;
				end
				default: begin
					next_cur.core_reg = cur.core_reg;
				end
			endcase
		end

		// Read data stands only in the cycle after the strobe
		next_cur.rdata = 8'h00;
		if (bus_i.rd) begin
			case (bus_i.addr)
				`LDCR_OFS_CORE: begin
					next_cur.rdata = cur.core_reg;
				end
				`LDCR_OFS_HYBRID: begin
					next_cur.rdata = cur.hyb_reg;
				end
				`LDCR_OFS_MODE: begin
					next_cur.rdata = cur.mode_reg;
				end
				`LDCR_OFS_TRIM: begin
					next_cur.rdata = cur.trim_reg;
				end
				default: begin
					next_cur.rdata = 8'h00;
				end
			endcase
		end

		// Decode from the new register values so controls move with the write edge
		slope_code = next_cur.hyb_reg[`LDCR_SLOPE_MSB:`LDCR_SLOPE_LSB];
		pclk_code  = next_cur.hyb_reg[`LDCR_PCLK_MSB:`LDCR_PCLK_LSB];
		dith_code  = next_cur.hyb_reg[`LDCR_DITH_MSB:`LDCR_DITH_LSB];
		src        = ldcr_brt_src_type'(next_cur.mode_reg[`LDCR_BRT_MSB:`LDCR_BRT_LSB]);

		next_cur.dim.hybrid_on = next_cur.core_reg[`LDCR_HYB_EN_BIT];
		if (next_cur.dim.hybrid_on) begin
			next_cur.dim.slope_gain = `LDCR_GAIN_UNITY
				+ 11'(slope_code) * `LDCR_GAIN_STEP;
			next_cur.dim.switch_pm = ldcr_swpt(
				next_cur.mode_reg[`LDCR_SWPT_MSB:`LDCR_SWPT_LSB]);
		end else begin
			// Pure PWM dimming: slope and switch point are held neutral
			next_cur.dim.slope_gain = `LDCR_GAIN_UNITY;
			next_cur.dim.switch_pm  = 10'h000;
		end

		next_cur.dim.pwm_clk_mhz = `LDCR_PCLK_BASE << pclk_code;

		case (dith_code)
			3'h0: begin
				next_cur.dim.dither_bits = 3'h0;
			end
			3'h1: begin
				next_cur.dim.dither_bits = 3'h1;
			end
			3'h2: begin
				next_cur.dim.dither_bits = 3'h2;
			end
			3'h3: begin
				next_cur.dim.dither_bits = 3'h3;
			end
			default: begin
				// Any code with the top bit set asks for the deepest dither
				next_cur.dim.dither_bits = 3'h4;
			end
		endcase

		next_cur.dim.use_resistor = next_cur.mode_reg[`LDCR_EXTRES_BIT];
		if (next_cur.dim.use_resistor) begin
			// Current set by the external resistor; register scale not applied
			next_cur.dim.max_ma = 8'h00;
		end else begin
			next_cur.dim.max_ma = ldcr_scale(
				next_cur.core_reg[`LDCR_SCALE_MSB:`LDCR_SCALE_LSB]);
		end

		// Live current setting: the FET choice may change on any cycle
		next_cur.dim.small_fet = next_cur.mode_reg[`LDCR_SPLIT_BIT]
			&& (cur_set_i[`LDCR_SMALL_MSB:`LDCR_SMALL_LSB] == 4'h0);

		next_cur.dim.brt_src       = src;
		next_cur.dim.direct_pwm_en = 1'b0;
		next_cur.dim.direct_pwm    = 1'b0;
		// Full product kept so the upper half scales duty by the register fraction
		prod = 32'(pwm_duty_i) * 32'(brt_reg_i);
		case (src)
			LDCR_BRT_PIN_DUTY: begin
				next_cur.dim.brightness = pwm_duty_i;
			end
			LDCR_BRT_DUTY_X_REG: begin
				next_cur.dim.brightness = prod[31:16];
			end
			LDCR_BRT_REG_ONLY: begin
				next_cur.dim.brightness = brt_reg_i;
			end
			LDCR_BRT_DIRECT: begin
				// Pin passes through with one register of delay
				next_cur.dim.brightness    = 16'h0000;
				next_cur.dim.direct_pwm_en = 1'b1;
				next_cur.dim.direct_pwm    = pwm_pin_i;
			end
			default: begin
				next_cur.dim.brightness = 16'h0000;
			end
		endcase

		next_cur.dim.trim1 = ldcr_trim(
			next_cur.trim_reg[`LDCR_TRIM1_MSB:`LDCR_TRIM1_LSB]);
		next_cur.dim.trim2 = ldcr_trim(
			next_cur.trim_reg[`LDCR_TRIM2_MSB:`LDCR_TRIM2_LSB]);
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			// Outputs equal the decode of the reset registers, except brightness, which loads 0 instead of pwm_duty_i
			cur                   <= '0;
			cur.core_reg          <= `LDCR_RST_CORE;
			cur.hyb_reg           <= `LDCR_RST_HYBRID;
			cur.mode_reg          <= `LDCR_RST_MODE;
			cur.trim_reg          <= `LDCR_RST_TRIM;
			cur.rdata             <= 8'h00;
			cur.dim.hybrid_on     <= 1'b0;
			cur.dim.slope_gain    <= `LDCR_GAIN_UNITY;
			cur.dim.switch_pm     <= 10'h000;
			cur.dim.pwm_clk_mhz   <= `LDCR_PCLK_BASE;
			cur.dim.dither_bits   <= 3'h0;
			cur.dim.use_resistor  <= 1'b0;
			cur.dim.max_ma        <= `LDCR_RST_MAX_MA;
			cur.dim.small_fet     <= 1'b0;
			cur.dim.brt_src       <= LDCR_BRT_PIN_DUTY;
			cur.dim.brightness    <= 16'h0000;
			cur.dim.direct_pwm_en <= 1'b0;
			cur.dim.direct_pwm    <= 1'b0;
			cur.dim.trim1         <= 8'sh00;
			cur.dim.trim2         <= 8'sh00;
		end else begin
			cur <= next_cur;
		end
	end

	assign rdata_o = cur.rdata;
	assign dim_o   = cur.dim;

endmodule : ldcr_bank

// *** testbench/ldcr_bank_sva.sv ***
// Port assertions for the dimming config bank.
// Assumes ldcr_pkg is compiled first; bound into every ldcr_bank.
`timescale 1ns/1ps
module ldcr_bank_sva (
	input wire logic                       clk_sys_i,  // Clock
	input wire logic                       rst_b_i,    // Reset, low
	input wire ldcr_pkg::ldcr_bus_req_type bus_i,      // Request
	input wire logic [7:0]                 rdata_o,    // Read data
	input wire logic [15:0]                pwm_duty_i, // Duty
	input wire logic                       pwm_pin_i,  // Pin
	input wire logic [15:0]                brt_reg_i,  // Brightness
	input wire logic [15:0]                cur_set_i,  // Current
	input wire ldcr_pkg::ldcr_dim_out_type dim_o       // Decode
);
	import ldcr_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	a_rsvd_reads_zero: assert property (bus_i.rd && bus_i.addr == 8'h66 |=> !rdata_o[7])
		else $error("reserved bit read set");
	a_duty_src: assert property ($past(rst_b_i) && $stable(dim_o.brt_src) && dim_o.brt_src == LDCR_BRT_PIN_DUTY
		|-> dim_o.brightness == $past(pwm_duty_i)) else $error("duty mode wrong");
	a_product_src: assert property ($past(rst_b_i) && $stable(dim_o.brt_src) && dim_o.brt_src == LDCR_BRT_DUTY_X_REG
		|-> dim_o.brightness == 16'((32'($past(pwm_duty_i)) * 32'($past(brt_reg_i))) >> 16)) else $error("product wrong");
	a_reg_src: assert property ($past(rst_b_i) && $stable(dim_o.brt_src) && dim_o.brt_src == LDCR_BRT_REG_ONLY
		|-> dim_o.brightness == $past(brt_reg_i)) else $error("register mode wrong");
	a_direct_pin: assert property ($past(rst_b_i) && $stable(dim_o.brt_src) && dim_o.brt_src == LDCR_BRT_DIRECT
		|-> dim_o.direct_pwm_en && dim_o.direct_pwm == $past(pwm_pin_i)) else $error("direct pin wrong");
	a_small_fet: assert property ($past(rst_b_i) && dim_o.small_fet |-> $past(cur_set_i[15:12]) == 4'h0)
		else $error("small fet above limit");
	a_dither_code: assert property (bus_i.wr && bus_i.addr == 8'h65 |=> dim_o.dither_bits ==
		($past(bus_i.wdata[2]) ? 3'h4 : {1'b0, $past(bus_i.wdata[1:0])})) else $error("dither wrong");
	a_pwm_clock: assert property (bus_i.wr && bus_i.addr == 8'h65 |=>
		dim_o.pwm_clk_mhz == 6'h05 << $past(bus_i.wdata[4:3])) else $error("pwm clock wrong");
	a_slope_step: assert property (bus_i.wr && bus_i.addr == 8'h65 && dim_o.hybrid_on |=>
		dim_o.slope_gain == 11'h400 + 11'h018 * $past(bus_i.wdata[7:5])) else $error("slope wrong");
	a_hybrid_off: assert property (!dim_o.hybrid_on |-> dim_o.slope_gain == 11'h400 && dim_o.switch_pm == 10'h000)
		else $error("hybrid off not plain");
	a_resistor_scale: assert property (dim_o.use_resistor |-> dim_o.max_ma == 8'h00)
		else $error("scale used with resistor");
	a_switch_top: assert property (bus_i.wr && bus_i.addr == 8'h66 && bus_i.wdata[6:4] == 3'h0 && dim_o.hybrid_on
		|=> dim_o.switch_pm == 10'h1F4) else $error("switch point wrong");
	a_trim1_zero: assert property (bus_i.wr && bus_i.addr == 8'h67 && bus_i.wdata[3:0] == 4'h7
		|=> dim_o.trim1 == 8'sh00) else $error("sink one trim not zero");
	a_trim2_zero: assert property (bus_i.wr && bus_i.addr == 8'h67 && bus_i.wdata[7:4] == 4'h7
		|=> dim_o.trim2 == 8'sh00) else $error("sink two trim not zero");
	a_rdata_idle: assert property ($past(rst_b_i) && !$past(bus_i.rd) |-> rdata_o == 8'h00)
		else $error("read data outside read cycle");
endmodule : ldcr_bank_sva

bind ldcr_bank ldcr_bank_sva i_sva (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .bus_i(bus_i), .rdata_o(rdata_o),
	.pwm_duty_i(pwm_duty_i), .pwm_pin_i(pwm_pin_i), .brt_reg_i(brt_reg_i), .cur_set_i(cur_set_i), .dim_o(dim_o));

// *** testbench/tb.sv ***
// Self-checking bench for the dimming config bank.
// Assumes ldcr_pkg compiled first; the bench drives every port.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
	$display("Error at %0t got %h expected %h", $time, g, e); end end
module tb;
	import ldcr_pkg::*;
	logic             clk_sys_i = 1'b0;
	logic             rst_b_i, pin, look, rd_d = 1'b0;
	ldcr_bus_req_type bus_i;
	ldcr_dim_out_type dim_o;
	logic [7:0]       rdata_o;
	logic [15:0]      duty, brt, cur, exp_q[$];
	logic [3:0]       sel;
	int               num_errors, comparisons;
	logic signed [7:0] trim_t[16] = '{8'h41, 8'h38, 8'h2F, 8'h25, 8'h1C, 8'h13, 8'h09, 8'h00,
		8'hF7, 8'hED, 8'hE4, 8'hDB, 8'hD1, 8'hC8, 8'hBF, 8'hB6};
	logic [9:0]       sw_t[8] = '{10'h1F4, 10'h196, 10'h139, 10'h0FA, 10'h0DB, 10'h0BC, 10'h09C, 10'h07D};
	logic [7:0]       ma_t[8] = '{8'h19, 8'h1E, 8'h32, 8'h3C, 8'h50, 8'h64, 8'h78, 8'h96};

	ldcr_bank i_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .bus_i(bus_i), .rdata_o(rdata_o),
		.pwm_duty_i(duty), .pwm_pin_i(pin), .brt_reg_i(brt), .cur_set_i(cur), .dim_o(dim_o));

	always #10 clk_sys_i = ~clk_sys_i;

	function automatic logic [15:0] fld(input logic [3:0] s);
		case (s)
			4'h0: return 16'(dim_o.slope_gain);
			4'h1: return 16'(dim_o.switch_pm);
			4'h2: return 16'(dim_o.pwm_clk_mhz);
			4'h3: return 16'(dim_o.dither_bits);
			4'h4: return 16'(dim_o.max_ma);
			4'h5: return 16'(dim_o.trim1);
			4'h6: return 16'(dim_o.trim2);
			4'h7: return dim_o.brightness;
			default: return {9'h000, dim_o.hybrid_on, dim_o.use_resistor, dim_o.brt_src,
				dim_o.direct_pwm_en, dim_o.direct_pwm, dim_o.small_fet};
		endcase
	endfunction : fld

	// Monitor: checks read data in the cycle after the strobe and peeked fields while look is set
	task automatic cmp(input logic [15:0] g);
		logic [15:0] e;
		e = exp_q.pop_front();
		`CHK(g, e)
	endtask : cmp

	always @(posedge clk_sys_i) begin
		if (rd_d)
			cmp(16'(rdata_o));
		if (look)
			cmp(fld(sel));
		rd_d <= bus_i.rd;
	end

	task automatic wr(input logic [7:0] a, d);
		bus_i <= '{a, d, 1'b1, 1'b0};
		look  <= 1'b0;
		@(posedge clk_sys_i);
	endtask : wr

	task automatic rd(input logic [7:0] a, e);
		exp_q.push_back(16'(e));
		bus_i <= '{a, 8'h00, 1'b0, 1'b1};
		look  <= 1'b0;
		@(posedge clk_sys_i);
	endtask : rd

	task automatic peek(input logic [3:0] s, input logic [15:0] e);
		exp_q.push_back(e);
		bus_i <= '0;
		look  <= 1'b1;
		sel   <= s;
		@(posedge clk_sys_i);
	endtask : peek

	task automatic summarize();
		if (exp_q.size() != 0)
			num_errors++;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	initial begin
		#200000;
		num_errors++;
		summarize();
	end

	initial begin
		logic [15:0] e;
		rst_b_i = 1'b0;
		bus_i = '0;
		look = 1'b0;
		sel = 4'h0;
		{duty, brt, cur, pin} = '0;
		void'($urandom(7410));
		repeat (16) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		@(posedge clk_sys_i);
		rd(8'h63, 8'h00);
		rd(8'h65, 8'h00);
		rd(8'h66, 8'h00);
		rd(8'h67, 8'h77);
		wr(8'h64, 8'hFF);
		rd(8'h64, 8'h00);
		wr(8'h66, 8'hFF);
		rd(8'h66, 8'h7F);
		$display("test registers done");
		for (int c = 0; c < 8; c++) begin
			wr(8'h63, {1'b0, 3'(c), 4'h1});
			wr(8'h66, {1'b0, 3'(c), 4'h0});
			wr(8'h65, {3'(c), 2'(c), 3'(c)});
			peek(4'h0, 16'h0400 + 16'(c) * 16'h0018);
			peek(4'h1, 16'(sw_t[c]));
			peek(4'h2, 16'h0005 << 2'(c));
			peek(4'h3, c > 3 ? 16'h0004 : 16'(c));
			peek(4'h4, 16'(ma_t[c]));
		end
		wr(8'h63, 8'h70);
		peek(4'h0, 16'h0400);
		peek(4'h1, 16'h0000);
		wr(8'h66, 8'h08);
		peek(4'h4, 16'h0000);
		$display("test decode done");
		for (int c = 0; c < 16; c++) begin
			wr(8'h67, {4'(c), 4'(15 - c)});
			peek(4'h5, 16'(trim_t[15 - c]));
			peek(4'h6, 16'(trim_t[c]));
		end
		$display("test trim done");
		for (int m = 0; m < 4; m++) begin
			duty <= 16'($urandom);
			brt  <= 16'($urandom);
			cur  <= m[0] ? 16'($urandom) & 16'h0FFF : 16'($urandom) | 16'h8000;
			pin  <= m[1];
			wr(8'h66, 8'h04 | 8'(m));
			e = m == 0 ? duty : m == 1 ? 16'((32'(duty) * 32'(brt)) >> 16) : m == 2 ? brt : 16'h0000;
			peek(4'h7, e);
			peek(4'h8, {9'h000, 1'b0, 1'b0, 2'(m), m == 3, m == 3 && pin, cur[15:12] == 4'h0});
		end
		$display("test brightness done");
		bus_i <= '0;
		look  <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		summarize();
	end
endmodule : tb
